// >>> core/sdft_top.sv
module sdft_top
   import sdft_pkg::*;
#(
   parameter int DRV_CYC_300  = sdft_pkg::DRV_US_300 * sdft_pkg::CLK_MHZ,
   parameter int DRV_CYC_450  = sdft_pkg::DRV_US_450 * sdft_pkg::CLK_MHZ,
   parameter int DRV_CYC_575  = sdft_pkg::DRV_US_575 * sdft_pkg::CLK_MHZ,
   parameter int DRV_CYC_850  = sdft_pkg::DRV_US_850 * sdft_pkg::CLK_MHZ,
   parameter int DRV_CYC_1150 = sdft_pkg::DRV_US_1150 * sdft_pkg::CLK_MHZ
) (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  srst,
   // avalon-mm slave
   input  wire logic [sdft_pkg::AW-1:0] avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   // external panel source clock pin
   input  wire logic                  ext_clk,
   // panel timing outputs
   output sdft_pkg::sdft_panel_t      panel
);
   import sdft_pkg::*;

   // registers
   sdft_frr_t   frr_ff;
   sdft_ccr_t   ccr_ff;
   sdft_mode_t  mode_ff;

   // bus slave state
   logic        wait_ff;
   logic [31:0] rdata_ff;
   logic        req;
   logic        wr_go;
   logic [7:0]  idx;
   logic [7:0]  rd_byte;
   sdft_frr_t   wr_frr;
   sdft_ccr_t   wr_ccr;
   sdft_mode_t  wr_mode;

   // external clock synchroniser
   logic        ext_s1_ff;
   logic        ext_s2_ff;
   logic        ext_s3_ff;
   logic        src_tick;

   // timing chain
   logic [PSW-1:0] ps_term;
   logic [2:0]     cd_term;
   logic [3:0]     k_term;
   logic           pre_tick;
   logic           hp_tick;
   logic           period_end;
   logic           frame_tick;
   logic           pclk_ff;

   // drive and frame state
   logic [DTW-1:0] drv_cnt_ff;
   logic           drv_on_ff;
   logic           half_mode;
   logic [DTW-1:0] drv_load;
   logic           blank_ff;
   logic [3:0]     contrast_ff;
   logic           frame_ff;
   logic           drive_out_ff;

   assign req   = avs_read || avs_write;
   assign idx   = avs_address[AW-1:IDX_LSB];
   assign wr_go = avs_write && !wait_ff && avs_byteenable[0];

   // write byte seen through each register layout
   assign wr_frr  = sdft_frr_t'(avs_writedata[7:0]);
   assign wr_ccr  = sdft_ccr_t'(avs_writedata[7:0]);
   assign wr_mode = sdft_mode_t'(avs_writedata[7:0]);

   // read mux
   always_comb begin
      rd_byte = 8'h00;
      unique case (idx)
         IDX_FRAME_RATE: begin
            rd_byte = {1'b0, frr_ff.frame_prescale_select, 1'b0, frr_ff.frame_clock_divide};
         end
         IDX_CONTRAST: begin
            rd_byte = ccr_ff;
         end
         IDX_MODE: begin
            rd_byte = {mode_ff.panel_clock_source_select, 1'b0, mode_ff.duty_select, 3'h0, mode_ff.blank};
         end
         IDX_STATUS: begin
            rd_byte = {drive_out_ff, pclk_ff, blank_ff, 1'b0, contrast_ff};
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   // one wait cycle per access
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wait_ff <= 1'b1;
      end else if (req && wait_ff) begin
         wait_ff <= 1'b0;
      end else begin
         wait_ff <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read && wait_ff) begin
         rdata_ff <= {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         frr_ff <= sdft_frr_t'(RST_FRAME_RATE);
      end else if (wr_go && idx == IDX_FRAME_RATE) begin
         frr_ff.frame_prescale_select <= wr_frr.frame_prescale_select;
         frr_ff.frame_clock_divide    <= wr_frr.frame_clock_divide;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ccr_ff <= sdft_ccr_t'(RST_CONTRAST);
      end else if (wr_go && idx == IDX_CONTRAST) begin
         ccr_ff <= wr_ccr;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mode_ff <= sdft_mode_t'(RST_MODE);
      end else if (wr_go && idx == IDX_MODE) begin
         mode_ff.panel_clock_source_select <= wr_mode.panel_clock_source_select;
         mode_ff.duty_select               <= wr_mode.duty_select;
         mode_ff.blank                     <= wr_mode.blank;
      end
   end

   // synchronise external clock
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_s3_ff <= 1'b0;
      end else begin
         ext_s1_ff <= ext_clk;
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
      end
   end

   assign src_tick = mode_ff.panel_clock_source_select ? (ext_s2_ff && !ext_s3_ff) : 1'b1;

   // prescaler tap at half of n
   assign ps_term = PS_HALF[frr_ff.frame_prescale_select] - 1'b1;
   assign cd_term = frr_ff.frame_clock_divide;
   assign k_term  = ((mode_ff.duty_select == DUTY_THIRD) ? K_THIRD : K_OTHER) - 1'b1;

   sdft_div #(
      .W (PSW)
   ) u_prescale (
      .ref_clk (ref_clk),
      .srst    (srst),
      .step    (src_tick),
      .term    (ps_term),
      .tick    (pre_tick)
   );

   sdft_div #(
      .W (3)
   ) u_divide (
      .ref_clk (ref_clk),
      .srst    (srst),
      .step    (pre_tick),
      .term    (cd_term),
      .tick    (hp_tick)
   );

   assign period_end = hp_tick && pclk_ff;

   sdft_div #(
      .W (4)
   ) u_frame (
      .ref_clk (ref_clk),
      .srst    (srst),
      .step    (period_end),
      .term    (k_term),
      .tick    (frame_tick)
   );

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pclk_ff <= 1'b0;
      end else if (hp_tick) begin
         pclk_ff <= !pclk_ff;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         frame_ff <= 1'b0;
      end else begin
         frame_ff <= frame_tick;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         contrast_ff <= 4'h0;
      end else if (frame_tick) begin
         contrast_ff <= ccr_ff.contrast_level;
      end
   end

   // blanking starts after frame completes
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         blank_ff <= 1'b0;
      end else if (frame_tick) begin
         blank_ff <= mode_ff.blank;
      end
   end

   // static or blanking forces half period
   assign half_mode = (ccr_ff.drive_time_select == DRV_HALF) ||
                      (mode_ff.duty_select == DUTY_STATIC) || blank_ff;

   always_comb begin
      drv_load = '0;
      unique case (ccr_ff.drive_time_select)
         DRV_300:  drv_load = DTW'(DRV_CYC_300 - 1);
         DRV_70:   drv_load = DTW'(DRV_CYC_70 - 1);
         DRV_150:  drv_load = DTW'(DRV_CYC_150 - 1);
         DRV_450:  drv_load = DTW'(DRV_CYC_450 - 1);
         DRV_575:  drv_load = DTW'(DRV_CYC_575 - 1);
         DRV_850:  drv_load = DTW'(DRV_CYC_850 - 1);
         DRV_1150: drv_load = DTW'(DRV_CYC_1150 - 1);
         DRV_HALF: drv_load = '0;
      endcase
   end

   // pulse per transition, cut at next one
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         drv_on_ff  <= 1'b0;
         drv_cnt_ff <= '0;
      end else if (hp_tick) begin
         drv_on_ff  <= 1'b1;
         drv_cnt_ff <= drv_load;
      end else if (half_mode) begin
         drv_cnt_ff <= '0;
      end else if (drv_cnt_ff == '0) begin
         drv_on_ff <= 1'b0;
      end else begin
         drv_cnt_ff <= drv_cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         drive_out_ff <= 1'b0;
      end else begin
         drive_out_ff <= ccr_ff.drive_always_on || (drv_on_ff && !(!hp_tick && !half_mode && drv_cnt_ff == '0))
                         || hp_tick;
      end
   end

   assign panel.contrast_level        = contrast_ff;
   assign panel.prescaled_panel_clock = pclk_ff;
   assign panel.drive_enable          = drive_out_ff;
   assign panel.frame_start           = frame_ff;
   assign panel.blank_active          = blank_ff;
   assign avs_readdata                = rdata_ff;
   assign avs_waitrequest             = wait_ff;

endmodule

// >>> inc/sdft_pkg.sv
// Overview of operation
// - prescaler divides panel source clock by 16..4096 per 3-bit select
// - clock divider further divides prescaler output by field value plus one
// - prescaler and divider cascade into the prescaled panel clock
// - one frame every K*N*D source cycles, K=6 for third duty else 8
// - frame rate bits 7 and 3 and reserved bits read as zero
// - drive time select picks 300/70/150/450/575/850/1150 us or half period
// - a drive time longer than half a prescaled panel clock period keeps drivers on continuously
// - static duty or blanking forces half-period drive time
// - always-on bit keeps drivers on continuously
// - 4-bit contrast level sets max drive voltage, 2.60 V plus 0.05 V steps
// - new contrast value applied only at next frame start
// - frame rate at 0xE6, contrast at 0xE7, both reset to zero
// - 2-bit duty select chooses static, half, third or quarter duty
// - source select zero uses system clock, one uses external clock
package sdft_pkg;

   // reference clock
   localparam int CLK_MHZ = 25;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_FRAME_RATE = 8'he6;
   localparam logic [7:0] IDX_CONTRAST   = 8'he7;
   localparam logic [7:0] IDX_MODE       = 8'he8;
   localparam logic [7:0] IDX_STATUS     = 8'he9;
   localparam logic [7:0] RST_FRAME_RATE = 8'h00;
   localparam logic [7:0] RST_CONTRAST   = 8'h00;
   localparam logic [7:0] RST_MODE       = 8'h00;
   localparam int         AW             = 10;
   localparam int         IDX_LSB        = 2;

   // prescaler half divide values, index is the prescale select code
   localparam int PSW = 12;
   localparam logic [PSW-1:0] PS_HALF [8] = '{12'h008, 12'h020, 12'h040, 12'h080,
                                             12'h100, 12'h200, 12'h400, 12'h800};

   // frame length in panel clock periods
   localparam logic [3:0] K_THIRD = 4'h6;
   localparam logic [3:0] K_OTHER = 4'h8;

   // nominal drive times in microseconds
   localparam int DRV_US_300  = 300;
   localparam int DRV_US_70   = 70;
   localparam int DRV_US_150  = 150;
   localparam int DRV_US_450  = 450;
   localparam int DRV_US_575  = 575;
   localparam int DRV_US_850  = 850;
   localparam int DRV_US_1150 = 1150;
   localparam int DRV_CYC_70  = DRV_US_70 * CLK_MHZ;
   localparam int DRV_CYC_150 = DRV_US_150 * CLK_MHZ;
   localparam int DTW         = 15;

   typedef enum logic [1:0] {
      DUTY_STATIC,
      DUTY_HALF,
      DUTY_THIRD,
      DUTY_QUARTER
   } sdft_duty_t;

   typedef enum logic [2:0] {
      DRV_300, DRV_70, DRV_150, DRV_450, DRV_575, DRV_850, DRV_1150, DRV_HALF
   } sdft_drv_t;

   typedef struct packed {
      logic       rsv7;
      logic [2:0] frame_prescale_select;
      logic       rsv3;
      logic [2:0] frame_clock_divide;
   } sdft_frr_t;

   typedef struct packed {
      sdft_drv_t  drive_time_select;
      logic       drive_always_on;
      logic [3:0] contrast_level;
   } sdft_ccr_t;

   typedef struct packed {
      logic       panel_clock_source_select;
      logic       rsv6;
      sdft_duty_t duty_select;
      logic [2:0] rsv3;
      logic       blank;
   } sdft_mode_t;

   typedef struct packed {
      logic       prescaled_panel_clock;
      logic       drive_enable;
      logic       frame_start;
      logic       blank_active;
      logic [3:0] contrast_level;
   } sdft_panel_t;

endpackage

// >>> core/sdft_div.sv
module sdft_div #(
   parameter int W = 12
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         srst,
   // count control
   input  wire logic         step,
   input  wire logic [W-1:0] term,
   // terminal pulse
   output logic              tick
);

   logic [W-1:0] cnt_ff;

   assign tick = step && (cnt_ff >= term);

   // counts steps, wraps at term
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_ff <= '0;
      end else if (tick) begin
         cnt_ff <= '0;
      end else if (step) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

endmodule

// >>> bench/sdft_top_chk.sv
module sdft_top_chk
   import sdft_pkg::*;
(
   // clock and reset
   input wire logic                    ref_clk,
   input wire logic                    srst,
   // bus
   input wire logic [sdft_pkg::AW-1:0] avs_address,
   input wire logic                    avs_read,
   input wire logic                    avs_write,
   input wire logic [31:0]             avs_writedata,
   input wire logic [3:0]              avs_byteenable,
   input wire logic [31:0]             avs_readdata,
   input wire logic                    avs_waitrequest,
   // panel
   input wire sdft_pkg::sdft_panel_t   panel
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   a_wait_one:
      assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low twice");
   a_req_answer:
      assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
   a_rd_upper:
      assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
   a_fs_pulse:
      assert property (panel.frame_start |=> !panel.frame_start) else $error("frame pulse long");
   a_contrast_frame:
      assert property ($changed(panel.contrast_level) |-> panel.frame_start) else $error("contrast mid frame");
   a_pclk_min:
      assert property ($changed(panel.prescaled_panel_clock) |=> $stable(panel.prescaled_panel_clock) [*7])
         else $error("clock too fast");
   a_drive_toggle:
      assert property ($changed(panel.prescaled_panel_clock) |-> ##[0:1] panel.drive_enable) else $error("no drive");
   a_always_on:
      assert property (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_writedata[4]
         && avs_address[9:2] == IDX_CONTRAST |-> ##[1:2] panel.drive_enable) else $error("drive not on");
endmodule

// >>> bench/sdft_panel_model.sv
module sdft_panel_model
   import sdft_pkg::*;
(
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  srst,
   // panel side
   input  wire sdft_pkg::sdft_panel_t panel,
   // measurements
   output logic [31:0]                gap_ff,
   output logic [31:0]                hi_run_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] fcnt_ff;
   logic [31:0] hcnt_ff;
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         fcnt_ff <= '0;
         gap_ff  <= '0;
      end else if (panel.frame_start) begin
         fcnt_ff <= 32'h1;
         gap_ff  <= fcnt_ff;
      end else begin
         fcnt_ff <= fcnt_ff + 32'h1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         hcnt_ff   <= '0;
         hi_run_ff <= '0;
      end else if (panel.drive_enable) begin
         hcnt_ff <= hcnt_ff + 32'h1;
      end else if (hcnt_ff != 32'h0) begin
         hi_run_ff <= hcnt_ff;
         hcnt_ff   <= '0;
      end
   end
endmodule

// >>> bench/sdft_top_tb_top.sv
module sdft_top_tb_top
   import sdft_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic          ref_clk = 1'b0;
   logic          srst = 1'b1;
   logic          ext_clk = 1'b0;
   logic [AW-1:0] adr = '0;
   logic          rd = 1'b0;
   logic          wr = 1'b0;
   logic [31:0]   wdat = '0;
   logic [3:0]    be = 4'hf;
   logic [31:0]   rdat;
   logic          wait_rq;
   sdft_panel_t   panel;
   logic [31:0]   gap;
   logic [31:0]   hi_run;
   logic [7:0]    v;
   int            n_mismatch = 0;
   int            num_checks = 0;
   always #20 ref_clk = ~ref_clk;
   always #120 ext_clk = ~ext_clk;
   sdft_top #(.DRV_CYC_300(20), .DRV_CYC_450(30), .DRV_CYC_575(40), .DRV_CYC_850(50), .DRV_CYC_1150(60)) dut (
      .ref_clk, .srst, .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
      .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_rq), .ext_clk, .panel);
   sdft_panel_model pm (.ref_clk, .srst, .panel, .gap_ff(gap), .hi_run_ff(hi_run));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
      int i;
      @(posedge ref_clk);
      adr <= {idx, 2'b00};
      rd <= !w;
      wr <= w;
      wdat <= {24'h0, d};
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (wait_rq !== 1'b0 && i < 50);
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      if (i >= 50) begin
         n_mismatch++;
         end_of_test();
      end
   endtask
   task automatic wfs(input int n);
      for (int i = 0; i < 40000 && n > 0; i++) begin
         @(posedge ref_clk);
         if (panel.frame_start === 1'b1) n--;
      end
      if (n > 0) begin
         n_mismatch++;
         end_of_test();
      end
   endtask
   task automatic cfg(input logic [7:0] f, input logic [7:0] m, input logic [7:0] c);
      bus(1'b1, IDX_FRAME_RATE, f, v);
      bus(1'b1, IDX_MODE, m, v);
      bus(1'b1, IDX_CONTRAST, c, v);
   endtask
   task automatic t_regs();
      bus(1'b0, IDX_FRAME_RATE, 8'h00, v);
      chk(v, 8'h00);
      bus(1'b0, IDX_CONTRAST, 8'h00, v);
      chk(v, 8'h00);
      bus(1'b1, IDX_FRAME_RATE, 8'hff, v);
      bus(1'b0, IDX_FRAME_RATE, 8'h00, v);
      chk(v, 8'h77);
      be <= 4'he;
      bus(1'b1, IDX_FRAME_RATE, 8'h00, v);
      be <= 4'hf;
      bus(1'b0, IDX_FRAME_RATE, 8'h00, v);
      chk(v, 8'h77);
      bus(1'b1, IDX_CONTRAST, 8'ha5, v);
      bus(1'b0, IDX_CONTRAST, 8'h00, v);
      chk(v, 8'ha5);
      bus(1'b0, 8'h10, 8'h00, v);
      chk(v, 8'h00);
      bus(1'b1, IDX_MODE, 8'hff, v);
      bus(1'b0, IDX_MODE, 8'h00, v);
      chk(v, 8'hb1);
      $display("test regs done");
   endtask
   task automatic t_frames();
      logic [7:0] f [5] = '{8'h00, 8'h01, 8'h10, 8'h07, 8'h00};
      logic [7:0] m [5] = '{8'h00, 8'h20, 8'h30, 8'h10, 8'h80};
      int nt [8] = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
      int e;
      for (int i = 0; i < 5; i++) begin
         cfg(f[i], m[i], 8'h00);
         wfs(3);
         e = (m[i][5:4] == 2'b10 ? 6 : 8) * nt[f[i][6:4]] * (f[i][2:0] + 1) * (m[i][7] ? 6 : 1);
         chk(gap, 32'(e));
      end
      $display("test frames done");
   endtask
   task automatic t_contrast();
      cfg(8'h00, 8'h00, 8'h00);
      wfs(1);
      bus(1'b1, IDX_CONTRAST, 8'h09, v);
      chk(32'(panel.contrast_level), 32'h0);
      wfs(1);
      chk(32'(panel.contrast_level), 32'h9);
      bus(1'b0, IDX_STATUS, 8'h00, v);
      chk(32'(v[3:0]), 32'h9);
      $display("test contrast done");
   endtask
   task automatic t_reset();
      srst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (2) begin
         @(posedge ref_clk);
         chk(32'(panel), 32'h0);
         chk(32'(wait_rq), 32'h1);
         chk(rdat, 32'h0);
      end
      bus(1'b0, IDX_FRAME_RATE, 8'h00, v);
      chk(v, 8'h00);
      bus(1'b0, IDX_CONTRAST, 8'h00, v);
      chk(v, 8'h00);
      bus(1'b0, IDX_MODE, 8'h00, v);
      chk(v, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_drive();
      logic [7:0] f [7] = '{8'h10, 8'h00, 8'h10, 8'h10, 8'h70, 8'h70, 8'h10};
      logic [7:0] m [7] = '{8'h30, 8'h30, 8'h30, 8'h00, 8'h30, 8'h30, 8'h31};
      logic [7:0] c [7] = '{8'h00, 8'h00, 8'he0, 8'h00, 8'h20, 8'h30, 8'h00};
      int cy [7] = '{256, 256, 256, 256, 4200, 4200, 256};
      int lows;
      for (int i = 0; i < 7; i++) begin
         cfg(f[i], m[i], c[i]);
         if (m[i][0]) begin
            wfs(2);
            chk(32'(panel.blank_active), 32'h1);
         end else begin
            repeat (64) @(posedge ref_clk);
            chk(32'(panel.blank_active), 32'h0);
         end
         lows = 0;
         repeat (cy[i]) begin
            @(posedge ref_clk);
            if (panel.drive_enable !== 1'b1) lows++;
         end
         chk(32'(lows == 0), 32'(i != 0 && i != 4));
         if (i == 0) chk(32'(hi_run inside {20, 21}), 32'h1);
      end
      $display("test drive done");
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      srst <= 1'b0;
      t_regs();
      t_frames();
      t_contrast();
      t_drive();
      t_reset();
      end_of_test();
   end
endmodule
bind sdft_top sdft_top_chk chk (.ref_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_byteenable, .avs_readdata, .avs_waitrequest, .panel);
